// file: ecm_map.svh
// Purpose: register offsets, field positions, reset values and mode codes of the capture unit
// Assumes: word-aligned registers on a 32-bit classic Wishbone bus
// Notes:   definitions only
`ifndef ECM_MAP_SVH
`define ECM_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define ECM_OFS_CONTROL     8'h00
`define ECM_OFS_HOLD_LOW    8'h04
`define ECM_OFS_HOLD_HIGH   8'h08
`define ECM_OFS_FLAG        8'h0c
`define ECM_OFS_ENABLE      8'h10
`define ECM_OFS_PIN         8'h14

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define ECM_CFG_MSB         7
`define ECM_CFG_LSB         6
`define ECM_DUTY_MSB        5
`define ECM_DUTY_LSB        4
`define ECM_MODE_MSB        3
`define ECM_MODE_LSB        0
`define ECM_PIN_DIR_BIT     0
`define ECM_PIN_DATA_BIT    1
`define ECM_RST_CONTROL     8'h00
`define ECM_RST_PIN         2'h1

// ----------------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------------
`define ECM_MODE_OFF        4'h0
`define ECM_MODE_CAP_GROUP  2'h1
`define ECM_MODE_PWM_GROUP  2'h3

`endif

// file: ecm_pkg.sv
// Purpose: shared types of the capture unit
// Assumes: nothing
// Notes:   enum order follows the field codes
package ecm_pkg;

  // capture event selection, low two mode bits in capture group
  typedef enum logic [1:0] {
    ECM_EDGE_FALL,
    ECM_EDGE_RISE,
    ECM_EDGE_RISE4,
    ECM_EDGE_RISE16
  } ecm_edge_type;

  // pwm output configuration
  typedef enum logic [1:0] {
    ECM_CFG_SINGLE,
    ECM_CFG_FULL_FWD,
    ECM_CFG_HALF,
    ECM_CFG_FULL_REV
  } ecm_outcfg_type;

endpackage

// file: ecm_edge_prescaler.sv
// Purpose: edge detector and event prescaler of the capture pin
// Assumes: sig_i is synchronous to clk_i
// Notes:   counter clears after each prescaled event, through clear_i or on reset
`timescale 1ns/10ps
module ecm_edge_prescaler
  import ecm_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire ecm_edge_type     edge_sel_i,
  input  wire logic             sig_i,
  output logic                  event_o,
  output logic [CNT_W-1:0]      count_o
);

  logic             prev_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire              rise_w = sig_i & ~prev_r;
  wire              fall_w = ~sig_i & prev_r;
  wire              div4_w = rise_w & (cnt_r >= CNT_W'(3));
  wire              div16_w = rise_w & (cnt_r == CNT_W'(15));

  // ----------------------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    event_o = 1'b0;
    case (edge_sel_i)
      ECM_EDGE_FALL:   event_o = fall_w;
      ECM_EDGE_RISE:   event_o = rise_w;
      ECM_EDGE_RISE4:  event_o = div4_w;
      ECM_EDGE_RISE16: event_o = div16_w;
      default:         event_o = 1'b0;
    endcase
    if (rise_w && (edge_sel_i == ECM_EDGE_RISE4 || edge_sel_i == ECM_EDGE_RISE16)) begin
      cnt_nxt = event_o ? '0 : cnt_r + CNT_W'(1);
    end
    if (clear_i) begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
      cnt_r  <= '0;
    end else begin
      prev_r <= sig_i;
      cnt_r  <= cnt_nxt;
    end
  end

  assign count_o = cnt_r;

endmodule // ecm_edge_prescaler

// file: ecm_capture_unit.sv
// Purpose: control decode, capture path and pwm steering of the capture/compare/pwm unit
// Assumes: classic Wishbone slave, timer count and pin input synchronous to clk_i
// Notes:   compare actions, waveform generation, dead band and shutdown live elsewhere
//
// Contract
// - capture copies 16-bit timer into hold pair
// - mode selects falling, rising, 4th, 16th edge
// - every capture sets the interrupt flag
// - flag cleared only by software
// - new capture overwrites unread hold value
// - port write feeds edge detector when output
// - duty bits are two duty LSbs
// - config 00 single, 10 half bridge
// - config 01 forward, 11 reverse full bridge
// - prescaler clears when off or not capture
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "ecm_map.svh"
module ecm_capture_unit
  import ecm_pkg::*;
#(
  parameter int TIMER_W = 16,
  parameter int PRESC_W = 4
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [TIMER_W-1:0] timer_count_i,
  input  wire logic               capture_pin_i,
  output logic                    capture_pin_o,
  output logic                    capture_pin_oe_o,
  input  wire logic               pwm_wave_i,
  output logic      [3:0]         pwm_out_o,
  output logic      [3:0]         pwm_own_o,
  output logic      [9:0]         duty_value_o,
  output logic                    irq_o
);

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [7:0]         ctl_r;
  logic [7:0]         hold_low_r;
  logic [7:0]         hold_high_r;
  logic               flag_r;
  logic               flag_nxt;
  logic               irq_en_r;
  logic [1:0]         pin_r;
  logic               ack_r;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic               cap_evt;
  logic               cap_evt_raw;
  logic [PRESC_W-1:0] presc_count;

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  wire         req_w       = wb_cyc_i & wb_stb_i;
  wire         wr_w        = req_w & wb_we_i & ack_r & wb_sel_i[0];
  wire         sel_ctl_w   = (wb_adr_i == `ECM_OFS_CONTROL);
  wire         sel_low_w   = (wb_adr_i == `ECM_OFS_HOLD_LOW);
  wire         sel_high_w  = (wb_adr_i == `ECM_OFS_HOLD_HIGH);
  wire         sel_flag_w  = (wb_adr_i == `ECM_OFS_FLAG);
  wire         sel_en_w    = (wb_adr_i == `ECM_OFS_ENABLE);
  wire         sel_pin_w   = (wb_adr_i == `ECM_OFS_PIN);
  wire [3:0]   mode_w      = ctl_r[`ECM_MODE_MSB:`ECM_MODE_LSB];
  wire [1:0]   duty_lsb_w  = ctl_r[`ECM_DUTY_MSB:`ECM_DUTY_LSB];
  wire         cap_mode_w  = (mode_w[3:2] == `ECM_MODE_CAP_GROUP);
  wire         pwm_mode_w  = (mode_w[3:2] == `ECM_MODE_PWM_GROUP);
  wire         pin_dir_w   = pin_r[`ECM_PIN_DIR_BIT];
  wire         pin_data_w  = pin_r[`ECM_PIN_DATA_BIT];
  wire         flag_clr_w  = wr_w & sel_flag_w & wb_dat_i[0];
  // a driven pin feeds its own port latch back into the detector
  wire         edge_src_w  = pin_dir_w ? capture_pin_i : pin_data_w;
  // off, or any mode outside the capture group, holds the prescaler clear
  wire         presc_clr_w = ~cap_mode_w;
  ecm_outcfg_type cfg_w;
  assign cfg_w = ecm_outcfg_type'(ctl_r[`ECM_CFG_MSB:`ECM_CFG_LSB]);

  // ----------------------------------------------------------------------------
  // edge detector and prescaler
  // ----------------------------------------------------------------------------
  ecm_edge_prescaler #(
    .CNT_W (PRESC_W)
  ) u_presc (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clear_i    (presc_clr_w),
    .edge_sel_i (ecm_edge_type'(mode_w[1:0])),
    .sig_i      (edge_src_w),
    .event_o    (cap_evt_raw),
    .count_o    (presc_count)
  );
  assign cap_evt = cap_evt_raw & cap_mode_w;

  // ----------------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0;
    if (sel_ctl_w) begin
      rdata_nxt[7:0] = ctl_r;
    end else if (sel_low_w) begin
      rdata_nxt[7:0] = hold_low_r;
    end else if (sel_high_w) begin
      rdata_nxt[7:0] = hold_high_r;
    end else if (sel_flag_w) begin
      rdata_nxt[0] = flag_r;
    end else if (sel_en_w) begin
      rdata_nxt[0] = irq_en_r;
    end else if (sel_pin_w) begin
      rdata_nxt[2:0] = {capture_pin_i, pin_r};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r   <= req_w & ~ack_r;
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ----------------------------------------------------------------------------
  // control and pin registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r    <= `ECM_RST_CONTROL;
      irq_en_r <= 1'b0;
      pin_r    <= `ECM_RST_PIN;
    end else begin
      if (wr_w && sel_ctl_w) begin
        ctl_r <= wb_dat_i[7:0];
      end
      if (wr_w && sel_en_w) begin
        irq_en_r <= wb_dat_i[0];
      end
      if (wr_w && sel_pin_w) begin
        pin_r <= wb_dat_i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // capture hold pair and flag
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_low_r  <= 8'h00;
      hold_high_r <= 8'h00;
    end else if (cap_evt) begin
      // later capture simply replaces the earlier one
      hold_low_r  <= timer_count_i[7:0];
      hold_high_r <= timer_count_i[15:8];
    end else begin
      if (wr_w && sel_low_w) begin
        hold_low_r <= wb_dat_i[7:0];
      end
      if (wr_w && sel_high_w) begin
        hold_high_r <= wb_dat_i[7:0];
      end
    end
  end

  // set wins over a same-cycle clear; no other path clears
  assign flag_nxt = cap_evt | (flag_r & ~flag_clr_w);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign irq_o = flag_r & irq_en_r;

  // ----------------------------------------------------------------------------
  // pin and pwm steering
  // ----------------------------------------------------------------------------
  assign capture_pin_o    = pin_data_w;
  assign capture_pin_oe_o = ~pin_dir_w;
  assign duty_value_o     = {hold_low_r, duty_lsb_w};

  logic [3:0] own_w;
  logic [3:0] lvl_w;
  always_comb begin
    own_w = 4'h0;
    lvl_w = 4'h0;
    if (pwm_mode_w) begin
      case (cfg_w)
        ECM_CFG_SINGLE: begin
          own_w = 4'b0001;
          lvl_w = {3'b000, pwm_wave_i};
        end
        ECM_CFG_HALF: begin
          own_w = 4'b0011;
          lvl_w = {2'b00, ~pwm_wave_i, pwm_wave_i};
        end
        ECM_CFG_FULL_FWD: begin
          own_w = 4'b1111;
          lvl_w = {pwm_wave_i, 3'b001};
        end
        ECM_CFG_FULL_REV: begin
          own_w = 4'b1111;
          lvl_w = {2'b01, pwm_wave_i, 1'b0};
        end
        default: begin
          own_w = 4'h0;
          lvl_w = 4'h0;
        end
      endcase
    end
  end

  // polarity: mode bit 1 inverts a and c, bit 0 inverts b and d
  wire [3:0] pol_w = pwm_mode_w ? {mode_w[0], mode_w[1], mode_w[0], mode_w[1]} : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_out_o <= 4'h0;
      pwm_own_o <= 4'h0;
    end else begin
      pwm_out_o <= own_w & (lvl_w ^ pol_w);
      pwm_own_o <= own_w;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  logic src_prev_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= edge_src_w;
    end
  end

  property p_capture_load;
    @(posedge clk_i) disable iff (rst_i) cap_evt |=> {hold_high_r, hold_low_r} == $past(timer_count_i);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("hold pair missed timer value");

  property p_falling_edge;
    @(posedge clk_i) disable iff (rst_i)
      (mode_w == 4'h4) |-> (cap_evt == (src_prev_r & ~edge_src_w));
  endproperty
  a_falling_edge: assert property (p_falling_edge) else $error("falling edge capture wrong");

  property p_every4;
    @(posedge clk_i) disable iff (rst_i)
      (mode_w == 4'h6) && cap_evt ##1 (mode_w == 4'h6) [*1] |-> presc_count == 4'h0;
  endproperty
  a_every4: assert property (p_every4) else $error("prescaler not restarted");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i) cap_evt |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("capture did not set flag");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (rst_i) flag_r && !flag_clr_w |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

  property p_overwrite;
    @(posedge clk_i) disable iff (rst_i)
      cap_evt ##1 !cap_evt ##1 cap_evt |=> hold_low_r == $past(timer_count_i[7:0]);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("second capture not stored");

  property p_port_feed;
    @(posedge clk_i) disable iff (rst_i) !pin_dir_w && (mode_w == 4'h5) && pin_data_w && !src_prev_r |-> cap_evt;
  endproperty
  a_port_feed: assert property (p_port_feed) else $error("port write gave no capture");

  property p_duty;
    @(posedge clk_i) disable iff (rst_i) $changed(ctl_r[5:4]) |-> duty_value_o[1:0] == ctl_r[5:4];
  endproperty
  a_duty: assert property (p_duty) else $error("duty low bits wrong");

  property p_single;
    @(posedge clk_i) disable iff (rst_i) pwm_mode_w && (ctl_r[7:6] == 2'b00) |=> pwm_own_o == 4'b0001;
  endproperty
  a_single: assert property (p_single) else $error("single output steering wrong");

  property p_reverse;
    @(posedge clk_i) disable iff (rst_i)
      (ctl_r[7:6] == 2'b11) && (mode_w == 4'hc) |=>
        (pwm_own_o == 4'hf) && (pwm_out_o[2] == 1'b1) && !pwm_out_o[0] && !pwm_out_o[3];
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse bridge levels wrong");

  property p_presc_clear;
    @(posedge clk_i) disable iff (rst_i) !cap_mode_w |=> presc_count == '0;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_off;
    @(posedge clk_i) disable iff (rst_i) (mode_w == `ECM_MODE_OFF) [*2] |-> !cap_evt && pwm_own_o == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("off mode left unit active");

endmodule // ecm_capture_unit

// file: ecm_pin_model.sv
// Purpose: external event source on the capture pin
// Assumes: levels launched just after clk_i rising edges
// Notes:   pin is always driven; gap sets fast or slow edges
`timescale 1ns/10ps
module ecm_pin_model (
  input  wire logic clk_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // ------
  // edge source
  // ------
  // the outside source drives the pin; software keeps it an input except in t_port, which makes it an output
  task automatic drive(input logic v, input int hold);
    @(posedge clk_i);
    pin_o <= v;
    repeat (hold) @(posedge clk_i);
  endtask
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      drive(1'b1, gap);
      drive(1'b0, gap);
    end
  endtask
endmodule // ecm_pin_model

// file: enhanced_capture_mode_control_tb.sv
// Purpose: self-checking bench of the capture unit
// Assumes: register map of ecm_map.svh
// Notes: timer held steady around each edge
`timescale 1ns/10ps
`include "ecm_map.svh"
module enhanced_capture_mode_control_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [15:0] timer = 16'h0;
  logic        wave  = 1'b0;
  logic [3:0]  wsel  = 4'h1;
  logic        pin;
  logic [31:0] rdat;
  logic        ack, pin_o, pin_oe, irq;
  logic [3:0]  pout, pown;
  logic [9:0]  duty;
  logic [7:0]  d;
  int          num_errors = 0;
  int          n_tests = 0;
  int          ticks = 0;
  ecm_capture_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_count_i(timer), .capture_pin_i(pin), .capture_pin_o(pin_o),
    .capture_pin_oe_o(pin_oe), .pwm_wave_i(wave), .pwm_out_o(pout), .pwm_own_o(pown),
    .duty_value_o(duty), .irq_o(irq));
  ecm_pin_model u_pin (.clk_i(clk_i), .pin_o(pin));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // ------
  // shared tasks
  // ------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= 1'b1;
    adr  <= a;
    wdat <= {24'h0, v};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    cyc <= 1'b1;
    adr <= a;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    d = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic flag_is(input logic f);
    rd(`ECM_OFS_FLAG);
    check("flag", {15'h0, d[0]}, {15'h0, f});
    wr(`ECM_OFS_FLAG, 8'h01);
  endtask
  task automatic pe(input int n, input logic f);
    u_pin.pulses(n, 1);
    flag_is(f);
  endtask
  task automatic hold_is(input logic [15:0] v);
    rd(`ECM_OFS_HOLD_LOW);
    check("hold_low", {8'h0, d}, {8'h0, v[7:0]});
    rd(`ECM_OFS_HOLD_HIGH);
    check("hold_high", {8'h0, d}, {8'h0, v[15:8]});
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rd(`ECM_OFS_CONTROL);
    check("control", {8'h0, d}, {8'h0, `ECM_RST_CONTROL});
    rd(`ECM_OFS_PIN);
    check("pin_reg", {8'h0, d}, 16'h0001);
    check("irq", {15'h0, irq}, 16'h0);
    check("own", {12'h0, pown}, 16'h0);
  endtask
  task automatic t_capture();
    wr(`ECM_OFS_CONTROL, 8'h05);
    timer <= 16'ha5c3;
    u_pin.pulses(1, 1);
    hold_is(16'ha5c3);
    repeat (20) @(posedge clk_i);
    wr(`ECM_OFS_ENABLE, 8'h01);
    @(posedge clk_i);
    check("irq_on", {15'h0, irq}, 16'h1);
    wr(`ECM_OFS_ENABLE, 8'h00);
    @(posedge clk_i);
    check("irq_masked", {15'h0, irq}, 16'h0);
    wr(`ECM_OFS_ENABLE, 8'h01);
    flag_is(1'b1);
    @(posedge clk_i);
    check("irq_clear", {15'h0, irq}, 16'h0);
    wr(`ECM_OFS_ENABLE, 8'h00);
    rd(8'h3c);
    check("unmapped", {8'h0, d}, 16'h0);
    wr(8'h3c, 8'hff);
    // lane 0 not selected: the control write must be ignored
    wsel <= 4'h0;
    wr(`ECM_OFS_CONTROL, 8'hff);
    wsel <= 4'h1;
    rd(`ECM_OFS_CONTROL);
    check("control_kept", {8'h0, d}, 16'h0005);
  endtask
  task automatic t_overwrite();
    timer <= 16'h1234;
    u_pin.pulses(1, 3);
    // rising edges two cycles apart, both captured
    u_pin.drive(1'b1, 0);
    u_pin.drive(1'b0, 0);
    timer <= 16'h5678;
    u_pin.drive(1'b1, 0);
    u_pin.drive(1'b0, 1);
    hold_is(16'h5678);
    wr(`ECM_OFS_CONTROL, 8'h04);
    timer <= 16'h1111;
    u_pin.drive(1'b1, 1);
    hold_is(16'h5678);
    timer <= 16'h2b4d;
    u_pin.drive(1'b0, 1);
    hold_is(16'h2b4d);
    flag_is(1'b1);
  endtask
  task automatic t_presc();
    wr(`ECM_OFS_CONTROL, 8'h06);
    pe(3, 1'b0);
    pe(1, 1'b1);
    wr(`ECM_OFS_CONTROL, 8'h00);
    wr(`ECM_OFS_CONTROL, 8'h07);
    pe(15, 1'b0);
    pe(1, 1'b1);
    wr(`ECM_OFS_CONTROL, 8'h06);
    pe(2, 1'b0);
    wr(`ECM_OFS_CONTROL, 8'h02);
    wr(`ECM_OFS_CONTROL, 8'h06);
    pe(2, 1'b0);
    pe(2, 1'b1);
    wr(`ECM_OFS_CONTROL, 8'h00);
    wr(`ECM_OFS_CONTROL, 8'h06);
    pe(2, 1'b0);
    wr(`ECM_OFS_CONTROL, 8'h07);
    pe(13, 1'b0);
    pe(1, 1'b1);
  endtask
  task automatic t_port();
    wr(`ECM_OFS_CONTROL, 8'h00);
    wr(`ECM_OFS_PIN, 8'h00);
    wr(`ECM_OFS_CONTROL, 8'h05);
    flag_is(1'b0);
    check("oe", {15'h0, pin_oe}, 16'h1);
    timer <= 16'h0f0e;
    wr(`ECM_OFS_PIN, 8'h02);
    @(posedge clk_i);
    check("latch", {15'h0, pin_o}, 16'h1);
    hold_is(16'h0f0e);
    flag_is(1'b1);
    wr(`ECM_OFS_PIN, 8'h01);
  endtask
  task automatic t_pwm();
    logic [3:0] own_t [4];
    logic [3:0] out_t [8];
    logic [1:0] c;
    own_t = '{4'h1, 4'hf, 4'h3, 4'hf};
    out_t = '{4'h0, 4'h1, 4'h1, 4'h9, 4'h2, 4'h1, 4'h4, 4'h6};
    wr(`ECM_OFS_HOLD_LOW, 8'h9d);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(`ECM_OFS_CONTROL, {c, c, 4'hc});
      for (int w = 0; w < 2; w++) begin
        wave <= w[0];
        repeat (3) @(posedge clk_i);
        check("pwm_out", {12'h0, pout}, {12'h0, out_t[2*i+w]});
      end
      check("duty", {6'h0, duty}, {6'h0, 8'h9d, c});
      check("own", {12'h0, pown}, {12'h0, own_t[i]});
    end
    wr(`ECM_OFS_CONTROL, 8'h0e);
    wave <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("pwm_pol", {12'h0, pout}, 16'h0001);
    wr(`ECM_OFS_CONTROL, 8'h00);
    repeat (2) @(posedge clk_i);
    check("own_off", {12'h0, pown}, 16'h0);
  endtask
  task automatic t_rerst();
    wr(`ECM_OFS_CONTROL, 8'h06);
    pe(2, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ECM_OFS_CONTROL);
    check("control_rst", {8'h0, d}, {8'h0, `ECM_RST_CONTROL});
    wr(`ECM_OFS_CONTROL, 8'h06);
    pe(3, 1'b0);
    pe(1, 1'b1);
  endtask
  task automatic final_report();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_capture();
    t_overwrite();
    t_presc();
    t_rerst();
    t_port();
    t_pwm();
    final_report();
  end
endmodule // enhanced_capture_mode_control_tb
